// file: include/timer_params.svh
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_CTL      10'h091
`define IDX_REL_L    10'h092
`define IDX_REL_H    10'h093
`define IDX_CNT_L    10'h094
`define IDX_CNT_H    10'h095
`define IDX_CFG      10'h096
`define IDX_STATUS   10'h097
`define IDX_MASK     10'h098
// ==========================================================
// Reset values
`define CTL_RESET    8'h00
`define CFG_RESET    8'h00
`define MASK_RESET   3'h7
// ==========================================================
// Config register field positions and writable bits
`define CFG_HIGH_SEL 0
`define CFG_LOW_SEL  1
`define CFG_SUSPEND  2
`define CFG_IRQ_EN   7
`define CFG_WMASK    8'h87
// ==========================================================
// Status and mask bit positions
`define ST_HIGH      0
`define ST_LOW       1
`define ST_CAP       2
// ==========================================================
// Timing counts
`define DIV12_LAST   4'hb
`define DIV8_LAST    3'h7
// ==========================================================
// Bus responses
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// file: include/timer_pkg.sv
package timer_pkg;
  // ========================================================
  // Control register layout
  typedef struct packed {
    logic       hi_flag;    // high_byte_overflow_flag
    logic       lo_flag;    // low_byte_overflow_flag
    logic       lo_int_en;  // low_byte_interrupt_enable
    logic       cap_en;     // lfo_capture_enable
    logic       split;      // split_mode_select
    logic       run;        // run_bit
    logic [1:0] xclk;       // alternate_clock_select
  } ctl_t;
  // ========================================================
  // Alternate clock codes
  typedef enum logic [1:0] {
    XCLK_DIV12 = 2'h0,
    XCLK_EXT8  = 2'h1,
    XCLK_RSVD  = 2'h2,
    XCLK_LFO8  = 2'h3
  } xclk_t;
endpackage

// file: hdl/clk_sync.sv
`timescale 1ns/10ps
`include "timer_params.svh"
// Three-stage synchroniser with edge pulses and a divide-by-8 tick
module clk_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic async_in,  // Raw pin level
  input  wire logic bypass,    // Suspend: skip agreement filter
  output logic      rise,      // One-cycle rising pulse
  output logic      fall,      // One-cycle falling pulse
  output logic      div_tick   // Every eighth rising edge
);
  logic       s1_r, s2_r, s3_r;  // Synchroniser stages
  logic       lvl_r, lvl_nxt;    // Filtered level
  logic       prv_r;             // Previous filtered level
  logic [2:0] div_r, div_nxt;    // Divide-by-8 counter

  // ========================================================
  // Next state; first stage feeds the second stage only
  always_comb begin
    lvl_nxt = lvl_r;
    // Suspend trades the filter for latency
    if (bypass) begin
      lvl_nxt = s2_r;
    end else if (s2_r == s3_r) begin
      lvl_nxt = s3_r;
    end
    div_nxt = rise ? div_r + 3'h1 : div_r;
  end

  assign rise     = lvl_r & ~prv_r;
  assign fall     = ~lvl_r & prv_r;
  assign div_tick = rise && (div_r == `DIV8_LAST);

  // ========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
      prv_r <= 1'b0;
      div_r <= 3'h0;
    end else begin
      s1_r  <= async_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
      prv_r <= lvl_r;
      div_r <= div_nxt;
    end
  end
endmodule

// file: hdl/byte_counter.sv
`timescale 1ns/10ps
// One counter byte with reload and software load
module byte_counter #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         inc,        // Count enable
  input  wire logic         reload,     // Load reload value
  input  wire logic [W-1:0] reload_val,
  input  wire logic         wr,         // Software load, wins
  input  wire logic [W-1:0] wr_val,
  output logic      [W-1:0] count,
  output logic              wrap        // All ones and counting
);
  logic [W-1:0] cnt_r, cnt_nxt;  // Count value

  // ========================================================
  // Next count
  always_comb begin
    cnt_nxt = cnt_r;
    if (wr) begin
      cnt_nxt = wr_val;
    end else if (reload) begin
      cnt_nxt = reload_val;
    end else if (inc) begin
      cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign wrap  = inc && (&cnt_r);
  assign count = cnt_r;

  // ========================================================
  // Register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// file: hdl/split_reload_timer.sv
`timescale 1ns/10ps
`include "timer_params.svh"
// Functional notes
// - High byte rollover sets high flag
// - High flag set requests interrupt when enabled
// - Flags stay set until software clears
// - Low byte rollover sets low flag always
// - Low interrupt enable adds low overflow interrupt
// - Capture copies count on LOW_FREQUENCY_OSCILLATOR falling edge
// - Split bit picks one or two counters
// - Run gates counter; split gates high only
// - Alternate field picks div12, ext8, LFO8
// - Sources synchronised always; suspend skips only the agreement filter
// - Alternate field shared; per-byte selects independent
// - Sixteen-bit rollover loads reload pair
// - Split overflow reloads each byte separately
// - Per-byte select one picks system clock
// - No timer interrupt while enable clear
module split_reload_timer #(
  parameter int AW = 12
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ext_osc_in,  // External oscillator pin
  input  wire logic          lfo_in,      // Low-frequency oscillator
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          wvalid,
  output logic               wready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  output logic               bvalid,
  input  wire logic          bready,
  output logic [1:0]         bresp,
  input  wire logic          arvalid,
  output logic               arready,
  input  wire logic [AW-1:0] araddr,
  output logic               rvalid,
  input  wire logic          rready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               irq          // Level interrupt
);
  import timer_pkg::*;

  // ========================================================
  // Declarations
  logic          aw_hold_r, aw_hold_nxt;   // Address held
  logic [AW-1:0] aw_addr_r, aw_addr_nxt;
  logic          w_hold_r, w_hold_nxt;     // Data held
  logic [7:0]    w_data_r, w_data_nxt;
  logic          w_lane_r, w_lane_nxt;     // Byte lane 0 strobe
  logic          awready_r, awready_nxt;
  logic          wready_r, wready_nxt;
  logic          bvalid_r, bvalid_nxt;
  logic [1:0]    bresp_r, bresp_nxt;
  logic          arready_r, arready_nxt;
  logic          rvalid_r, rvalid_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  logic [1:0]    rresp_r, rresp_nxt;
  logic          do_wr;                    // Write commits now
  logic [9:0]    wr_idx;
  logic          ctl_wr, st_wr;            // Register write strobes
  ctl_t          ctl_r, ctl_nxt;           // timer_three_control
  logic [7:0]    cfg_r, cfg_nxt;           // Clock selects and enable
  logic [2:0]    st_r, st_nxt;             // Sticky events
  logic [2:0]    mask_r, mask_nxt;
  logic [7:0]    rel_l_r, rel_l_nxt;       // reload_low_byte
  logic [7:0]    rel_h_r, rel_h_nxt;       // reload_high_byte
  logic          irq_r, irq_nxt;
  logic [3:0]    div_r, div_nxt;           // Divide-by-12 counter
  logic          tick12;
  logic          ext_tick, lfo_tick, lfo_fall;
  logic          tick_l, tick_h;           // Per-byte count enables
  logic          inc_l, inc_h, wrap_l, wrap_h, reload_l;
  logic [7:0]    cnt_l, cnt_h;             // Count bytes
  logic          cap_evt;                  // Capture this cycle
  logic [2:0]    events;

  // Source for one byte: system clock or alternate
  function automatic logic pick_tick(input logic sys_sel, input logic [1:0] xclk,
                                     input logic t12, input logic te, input logic tl);
    logic t;
    t = 1'b0;
    if (sys_sel) begin
      t = 1'b1;
    end else begin
      case (xclk)
        XCLK_DIV12: t = t12;
        XCLK_EXT8:  t = te;
        XCLK_LFO8:  t = tl;
        default:    t = 1'b0;        // Reserved code stops counting
      endcase
    end
    return t;
  endfunction

  // ========================================================
  // Clock sources
  clk_sync u_ext_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (ext_osc_in),
    .bypass   (cfg_r[`CFG_SUSPEND]),
    .rise     (),
    .fall     (),
    .div_tick (ext_tick)
  );

  clk_sync u_lfo_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (lfo_in),
    .bypass   (cfg_r[`CFG_SUSPEND]),
    .rise     (),
    .fall     (lfo_fall),
    .div_tick (lfo_tick)
  );

  assign tick12 = (div_r == `DIV12_LAST);

  // In 16-bit mode the whole counter follows the low byte select
  always_comb begin
    div_nxt = tick12 ? 4'h0 : div_r + 4'h1;
    tick_l  = pick_tick(cfg_r[`CFG_LOW_SEL], ctl_r.xclk, tick12, ext_tick, lfo_tick);
    tick_h  = pick_tick(cfg_r[`CFG_HIGH_SEL], ctl_r.xclk, tick12, ext_tick,
                        lfo_tick);
  end

  // ========================================================
  // Counter structure
  always_comb begin
    if (ctl_r.split) begin
      inc_l    = tick_l;
      inc_h    = ctl_r.run && tick_h;
      reload_l = wrap_l;
    end else begin
      inc_l    = ctl_r.run && tick_l;
      inc_h    = wrap_l;             // Carry from low byte
      reload_l = wrap_h;
    end
  end

  byte_counter #(.W(8)) u_cnt_l (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .inc        (inc_l),
    .reload     (reload_l),
    .reload_val (rel_l_r),
    .wr         (do_wr && w_lane_r && (wr_idx == `IDX_CNT_L)),
    .wr_val     (w_data_r),
    .count      (cnt_l),
    .wrap       (wrap_l)
  );

  byte_counter #(.W(8)) u_cnt_h (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .inc        (inc_h),
    .reload     (wrap_h),
    .reload_val (rel_h_r),
    .wr         (do_wr && w_lane_r && (wr_idx == `IDX_CNT_H)),
    .wr_val     (w_data_r),
    .count      (cnt_h),
    .wrap       (wrap_h)
  );

  // ========================================================
  // Write channel: address and data taken in either order
  assign do_wr  = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_idx = aw_addr_r[11:2];
  assign ctl_wr = do_wr && w_lane_r && (wr_idx == `IDX_CTL);
  assign st_wr  = do_wr && w_lane_r && (wr_idx == `IDX_STATUS);

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_lane_nxt  = w_lane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (awvalid && awready_r) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = wdata[7:0];
      w_lane_nxt = wstrb[0];
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      // Unmapped words answer with an error and change nothing
      bresp_nxt   = (wr_idx >= `IDX_CTL && wr_idx <= `IDX_MASK) ? `RESP_OKAY
                                                               : `RESP_SLVERR;
    end
    awready_nxt = !aw_hold_nxt;
    wready_nxt  = !w_hold_nxt;
  end

  // ========================================================
  // Read channel: data one cycle after the address is taken
  always_comb begin
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (rvalid_r && rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    if (arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = `RESP_OKAY;
      case (araddr[11:2])
        `IDX_CTL:    rdata_nxt = {24'h0, ctl_r};
        `IDX_REL_L:  rdata_nxt = {24'h0, rel_l_r};
        `IDX_REL_H:  rdata_nxt = {24'h0, rel_h_r};
        `IDX_CNT_L:  rdata_nxt = {24'h0, cnt_l};
        `IDX_CNT_H:  rdata_nxt = {24'h0, cnt_h};
        `IDX_CFG:    rdata_nxt = {24'h0, cfg_r};
        `IDX_STATUS: rdata_nxt = {29'h0, st_r};
        `IDX_MASK:   rdata_nxt = {29'h0, mask_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = `RESP_SLVERR;
        end
      endcase
    end
    // Ready whenever no read answer is pending, so it rises after reset
    arready_nxt = !rvalid_nxt;
  end

  // ========================================================
  // Control, reload, config and interrupt state
  assign cap_evt = ctl_r.cap_en && lfo_fall;
  assign events  = {cap_evt, wrap_l && ctl_r.lo_int_en, wrap_h};

  always_comb begin
    ctl_nxt   = ctl_r;
    rel_l_nxt = rel_l_r;
    rel_h_nxt = rel_h_r;
    cfg_nxt   = cfg_r;
    mask_nxt  = mask_r;
    if (ctl_wr) begin
      ctl_nxt = ctl_t'(w_data_r);
    end
    // Hardware set applied after the write so it wins
    if (wrap_h || cap_evt) begin
      ctl_nxt.hi_flag = 1'b1;
    end
    if (wrap_l) begin
      ctl_nxt.lo_flag = 1'b1;
    end
    if (do_wr && w_lane_r && wr_idx == `IDX_REL_L) begin
      rel_l_nxt = w_data_r;
    end
    if (do_wr && w_lane_r && wr_idx == `IDX_REL_H) begin
      rel_h_nxt = w_data_r;
    end
    if (cap_evt) begin
      rel_l_nxt = cnt_l;
      rel_h_nxt = cnt_h;
    end
    if (do_wr && w_lane_r && wr_idx == `IDX_CFG) begin
      cfg_nxt = w_data_r & `CFG_WMASK;
    end
    if (do_wr && w_lane_r && wr_idx == `IDX_MASK) begin
      mask_nxt = w_data_r[2:0];
    end
    // Write one to clear; a new event in the same cycle survives
    st_nxt  = (st_r & ~(st_wr ? w_data_r[2:0] : 3'h0)) | events;
    // Single gate on the shared enable
    irq_nxt = cfg_r[`CFG_IRQ_EN] && |(st_r & mask_r);
  end

  // ========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= `RESP_OKAY;
      ctl_r     <= ctl_t'(`CTL_RESET);
      cfg_r     <= `CFG_RESET;
      st_r      <= 3'h0;
      mask_r    <= `MASK_RESET;
      rel_l_r   <= 8'h00;
      rel_h_r   <= 8'h00;
      irq_r     <= 1'b0;
      div_r     <= 4'h0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r  <= w_hold_nxt;
      w_data_r  <= w_data_nxt;
      w_lane_r  <= w_lane_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      ctl_r     <= ctl_nxt;
      cfg_r     <= cfg_nxt;
      st_r      <= st_nxt;
      mask_r    <= mask_nxt;
      rel_l_r   <= rel_l_nxt;
      rel_h_r   <= rel_h_nxt;
      irq_r     <= irq_nxt;
      div_r     <= div_nxt;
    end
  end

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  assign irq     = irq_r;

  // ========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_high_flag_set: assert property (wrap_h |=> ctl_r.hi_flag)
    else $error("high flag not set on rollover");
  chk_high_irq: assert property ((wrap_h && mask_r[`ST_HIGH] && cfg_r[`CFG_IRQ_EN])
    ##1 cfg_r[`CFG_IRQ_EN] |=> irq_r)
    else $error("no interrupt after high overflow");
  chk_flag_sticky: assert property (ctl_r.hi_flag && !ctl_wr |=> ctl_r.hi_flag)
    else $error("high flag dropped without write");
  chk_low_flag_set: assert property (wrap_l |=> ctl_r.lo_flag)
    else $error("low flag not set on rollover");
  chk_low_irq: assert property ((wrap_l && ctl_r.lo_int_en && mask_r[`ST_LOW]
    && cfg_r[`CFG_IRQ_EN]) ##1 cfg_r[`CFG_IRQ_EN] |=> irq_r)
    else $error("no interrupt after low overflow");
  chk_capture_copy: assert property (cap_evt |=>
    {rel_h_r, rel_l_r} == $past({cnt_h, cnt_l}) && ctl_r.hi_flag)
    else $error("capture did not copy count");
  chk_split_low_run: assert property (ctl_r.split && !ctl_r.run && tick_l
    && cnt_l != 8'hff && !do_wr |=> cnt_l == $past(cnt_l) + 8'h01)
    else $error("low byte halted in split mode");
  chk_stopped_hold: assert property (!ctl_r.split && !ctl_r.run && !do_wr
    |=> $stable({cnt_h, cnt_l}))
    else $error("counter moved while stopped");
  chk_full_reload: assert property (!ctl_r.split && wrap_h && !do_wr
    |=> {cnt_h, cnt_l} == $past({rel_h_r, rel_l_r}))
    else $error("16-bit reload missing");
  chk_split_reload: assert property (ctl_r.split && wrap_l && !do_wr
    |=> cnt_l == $past(rel_l_r))
    else $error("low byte reload missing");
  chk_irq_gate: assert property (!cfg_r[`CFG_IRQ_EN] |=> !irq_r)
    else $error("interrupt while disabled");
  chk_set_wins: assert property (wrap_h && ctl_wr |=> ctl_r.hi_flag)
    else $error("clear beat overflow");
endmodule

// file: verification/split_reload_timer_tb.sv
`timescale 1ns/10ps
`include "timer_params.svh"
module split_reload_timer_tb;
  // ==========================================================
  // Bench signals
  logic        aclk;
  logic        aresetn;
  logic        ext_osc_in;
  logic        lfo_in;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  rd;       // Last read byte
  logic [1:0]  rs;       // Last response code
  logic [2:0]  osc_div;  // Oscillator toggle divider
  int          err_count;
  int          checks_done;
  int          lo_lim[4] = '{39, 13, 0, 13};  // Ticks per source code
  int          hi_lim[4] = '{42, 16, 0, 16};

  split_reload_timer u_split_reload_timer (
    .aclk(aclk), .aresetn(aresetn), .ext_osc_in(ext_osc_in), .lfo_in(lfo_in),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq)
  );

  // ==========================================================
  // Clock, 5 ns period
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Both oscillators run free at a quarter of the clock
  always @(posedge aclk) begin
    osc_div <= osc_div + 3'h1;
    if (osc_div[0]) begin
      ext_osc_in <= ~ext_osc_in;
      lfo_in     <= ~lfo_in;
    end
  end

  // ==========================================================
  // Checks and verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [7:0] got, input int lo, input int hi);
    checks_done++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      err_count++;
      $display("[ERR] %0t count %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus tasks: entered right after a rising edge
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    int n;
    bit done;
    n = 0;
    done = 0;
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      // Each channel released only at its own handshake edge
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs     = bresp;
        bready <= 1'b0;
        done   = 1;
      end
    end
    if (!done) begin
      err_count++;
      $display("[ERR] %0t write never answered", $time);
    end
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [9:0] idx);
    int n;
    bit done;
    n = 0;
    done = 0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd     = rdata[7:0];
        rs     = rresp;
        rready <= 1'b0;
        done   = 1;
      end
    end
    if (!done) begin
      err_count++;
      $display("[ERR] %0t read never answered", $time);
    end
    @(posedge aclk);
  endtask

  // ==========================================================
  // Watchdog: the tests need about 2500 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial begin
    aresetn = 1'b0;
    ext_osc_in = 1'b0;
    lfo_in = 1'b1;
    osc_div = 3'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    wstrb = 4'h1;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and an unmapped place
    rd_reg(`IDX_CTL);
    chk(rd, 8'h00);
    rd_reg(`IDX_MASK);
    chk(rd, 8'h07);
    rd_reg(10'h0a0);
    chk({6'h0, rs}, 8'h02);
    wr(10'h0a0, 8'h55);
    chk({6'h0, rs}, 8'h02);
    // Every alternate source code, cfg selects the alternate
    for (int c = 0; c < 4; c++) begin
      wr(`IDX_CNT_L, 8'h00);
      wr(`IDX_CTL, 8'h04 | 8'(c));
      repeat (480) @(posedge aclk);
      wr(`IDX_CTL, 8'h00);
      rd_reg(`IDX_CNT_L);
      chk_rng(rd, lo_lim[c], hi_lim[c]);
    end
    // Split mode, run clear, both bytes on the system clock
    wr(`IDX_CFG, 8'h03);
    wr(`IDX_CNT_H, 8'h12);
    wr(`IDX_REL_L, 8'hf0);
    wr(`IDX_CNT_L, 8'hf0);
    wr(`IDX_CTL, 8'h28);
    repeat (60) @(posedge aclk);
    rd_reg(`IDX_CTL);
    chk(rd, 8'h68);
    rd_reg(`IDX_STATUS);
    chk(rd & 8'h02, 8'h02);
    rd_reg(`IDX_CNT_H);
    chk(rd, 8'h12);
    rd_reg(`IDX_CNT_L);
    chk_rng(rd, 8'hf0, 8'hff);
    chk({7'h0, irq}, 8'h00);
    // Sixteen-bit rollover with reload 0xff00, interrupt on
    wr(`IDX_CTL, 8'h00);
    wr(`IDX_STATUS, 8'h07);
    wr(`IDX_CFG, 8'h82);
    wr(`IDX_REL_L, 8'h00);
    wr(`IDX_REL_H, 8'hff);
    wr(`IDX_CNT_L, 8'h00);
    wr(`IDX_CNT_H, 8'hff);
    wr(`IDX_CTL, 8'h04);
    repeat (300) @(posedge aclk);
    rd_reg(`IDX_CTL);
    chk(rd, 8'hc4);
    chk({7'h0, irq}, 8'h01);
    wr(`IDX_CTL, 8'h00);
    rd_reg(`IDX_CNT_H);
    chk(rd, 8'hff);
    rd_reg(`IDX_CTL);
    chk(rd, 8'h00);
    chk({7'h0, irq}, 8'h01);
    wr(`IDX_STATUS, 8'h07);
    repeat (3) @(posedge aclk);
    chk({7'h0, irq}, 8'h00);
    // Capture on the slow oscillator's falling edge
    wr(`IDX_REL_L, 8'h00);
    wr(`IDX_REL_H, 8'h00);
    wr(`IDX_CNT_L, 8'h00);
    wr(`IDX_CNT_H, 8'h00);
    wr(`IDX_CTL, 8'h14);
    repeat (40) @(posedge aclk);
    wr(`IDX_CFG, 8'h80);
    rd_reg(`IDX_CTL);
    chk(rd & 8'h80, 8'h80);
    chk({7'h0, irq}, 8'h01);
    rd_reg(`IDX_REL_L);
    chk_rng(rd, 1, 255);
    summarize();
  end
endmodule
